// >>> rtl/wdc_watchdog.sv
`timescale 1ns/100ps
// Summary of operation
// - programmed fuse forces reset mode: reset enable one, interrupt enable zero.
// - change-unlock clears itself four core cycles after being written one.
// - clearing reset enable or changing select only accepted while unlocked.
// - bit 7 timeout flag sets on timeout when configured for interrupt.
// - flag clears on vector taken or on writing one; zero does nothing.
// - interrupt request needs flag, enable bit 6 and global enable.
// - combined mode: first timeout sets flag; vector clears flag and enable.
// - combined mode: flag still pending at next timeout causes system reset.
// - enable pair selects stopped, interrupt, reset, or interrupt-then-reset mode.
// - fuse value one is unprogrammed, zero is programmed.
// - bit 3 reads and acts set while cause flag set; clears only after.
// - select code gives 2048 shl code oscillator cycles; codes above nine reserved.
// - counter runs on 128 kHz oscillator ticks, compared to selected limit.
// - restart instruction clears the counter to zero.
// - watchdog reset sets cause flag; cleared by power-on or writing zero.
// - timeout reset pulse lasts exactly one core clock cycle.
module wdc_watchdog #(
  parameter int BASE_CYCLES = wdc_pkg::BASE_OSC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core and system side
  input wire logic osc_tick,
  input wire logic restart_instr,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic other_reset_req,
  input wire logic always_on_fuse,
  output logic irq_req,
  output logic wdt_reset_pulse,
  output logic [wdc_pkg::COUNT_W-1:0] watchdog_count
);

  // bus state
  wdc_pkg::wdc_bus_state_t bus_state_reg;
  wdc_pkg::wdc_bus_state_t bus_state_next;
  wdc_pkg::wdc_aphase_t aphase_reg;
  wdc_pkg::wdc_aphase_t aphase_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // watchdog state
  wdc_pkg::wdc_ctrl_t ctrl_reg;
  wdc_pkg::wdc_ctrl_t ctrl_next;
  logic [2:0] unlock_cnt_reg;
  logic [2:0] unlock_cnt_next;
  logic cause_reg;
  logic cause_next;
  logic pulse_reg;
  logic pulse_next;

  // decoded terms
  logic fuse_prog;
  logic wde_eff;
  logic ie_eff;
  logic unlock_active;
  logic run;
  logic timeout;
  logic ctrl_we;
  logic cause_we;
  logic [7:0] wbyte;
  logic set_flag;
  logic fire;
  logic reinit;
  logic addr_take;
  logic [7:0] ctrl_read;
  logic sel_ctrl;
  logic sel_cause;
  logic cnt_restart;

  // timeout behaviour selected by the effective enable pair
  typedef enum logic [3:0] {
    MODE_STOPPED = 4'b0001,
    MODE_IRQ = 4'b0010,
    MODE_RESET = 4'b0100,
    MODE_IRQ_RESET = 4'b1000
  } wdc_mode_t;
  wdc_mode_t mode;

  // effective mode bits; the fuse and the cause flag override software
  always_comb
  begin
    fuse_prog = (always_on_fuse == wdc_pkg::FUSE_PROGRAMMED);
    wde_eff = fuse_prog | ctrl_reg.reset_enable_bit | cause_reg;
    ie_eff = ctrl_reg.ie & ~fuse_prog;
    unlock_active = (unlock_cnt_reg != 3'h0);
    run = wde_eff | ie_eff;
  end

  // mode decode from the effective bits, so the fuse and the cause flag are already folded in
  always_comb
  begin
    case ({wde_eff, ie_eff})
      2'b01: mode = MODE_IRQ;
      2'b10: mode = MODE_RESET;
      2'b11: mode = MODE_IRQ_RESET;
      default: mode = MODE_STOPPED;
    endcase
  end

  // counter restart; our own timeout already zeroes the count, and keeping the reset pulse
  // out of this path keeps the timeout decode free of a combinational loop
  always_comb
  begin
    cnt_restart = restart_instr | other_reset_req;
  end

  // oscillator counter; cleared by restart and by any reset
  wdc_counter #(
    .BASE_CYCLES(BASE_CYCLES),
    .CNT_W(wdc_pkg::COUNT_W)
  ) u_counter (
    .sys_clk(sys_clk),
    .reset(reset),
    .restart(cnt_restart),
    .run(run),
    .osc_tick(osc_tick),
    .tsel(ctrl_reg.tsel),
    .timeout(timeout),
    .count(watchdog_count)
  );

  // timeout action by mode; a vector taken this cycle counts as serviced
  always_comb
  begin
    set_flag = 1'b0;
    fire = 1'b0;
    if (timeout)
    begin
      case (mode)
        MODE_IRQ:
        begin
          set_flag = 1'b1;
        end
        MODE_IRQ_RESET:
        begin
          if (ctrl_reg.flag && !irq_vector_taken)
            fire = 1'b1;
          else
            set_flag = 1'b1;
        end
        MODE_RESET:
        begin
          fire = 1'b1;
        end
        default:
        begin
          fire = 1'b0;
        end
      endcase
    end
    reinit = fire | other_reset_req;
  end

  // bus address phase and data-phase sequencing
  always_comb
  begin
    addr_take = hsel & hready & (htrans == wdc_pkg::HTRANS_NONSEQ);
    aphase_next = aphase_reg;
    bus_state_next = bus_state_reg;
    hrdata_next = hrdata_reg;
    case (bus_state_reg)
      wdc_pkg::BUS_IDLE, wdc_pkg::BUS_WRITE, wdc_pkg::BUS_RD_DONE:
      begin
        aphase_next.valid = addr_take;
        aphase_next.write = hwrite;
        aphase_next.addr = haddr[wdc_pkg::ADDR_W-1:0];
        if (!addr_take)
          bus_state_next = wdc_pkg::BUS_IDLE;
        else if (hwrite)
          bus_state_next = wdc_pkg::BUS_WRITE;
        else
          bus_state_next = wdc_pkg::BUS_RD_WAIT;
      end
      wdc_pkg::BUS_RD_WAIT:
      begin
        // one wait state lets read data leave from a flip-flop
        if (sel_ctrl)
          hrdata_next = {24'h000000, ctrl_read};
        else if (sel_cause)
          hrdata_next = 32'(cause_reg) << wdc_pkg::CAUSE_BIT;
        else
          hrdata_next = 32'h00000000;
        bus_state_next = wdc_pkg::BUS_RD_DONE;
      end
      default:
      begin
        bus_state_next = wdc_pkg::BUS_IDLE;
        aphase_next.valid = 1'b0;
      end
    endcase
  end

  // read view of the control register
  always_comb
  begin
    ctrl_read = 8'h00;
    ctrl_read[wdc_pkg::FLAG_BIT] = ctrl_reg.flag;
    ctrl_read[wdc_pkg::IE_BIT] = ie_eff;
    ctrl_read[wdc_pkg::TSEL3_BIT] = ctrl_reg.tsel[3];
    ctrl_read[wdc_pkg::UNLOCK_BIT] = unlock_active;
    ctrl_read[wdc_pkg::WDE_BIT] = wde_eff;
    ctrl_read[wdc_pkg::TSEL_LO_MSB:0] = ctrl_reg.tsel[2:0];
  end

  // register select from the captured address phase; write strobes in the data phase
  always_comb
  begin
    wbyte = hwdata[7:0];
    sel_ctrl = aphase_reg.valid && (aphase_reg.addr == wdc_pkg::CTRL_STATUS_ADDR);
    sel_cause = aphase_reg.valid && (aphase_reg.addr == wdc_pkg::RESET_CAUSE_ADDR);
    ctrl_we = (bus_state_reg == wdc_pkg::BUS_WRITE) && sel_ctrl;
    cause_we = (bus_state_reg == wdc_pkg::BUS_WRITE) && sel_cause;
  end

  // unlock window: loaded by the unlocking write, then counts down
  always_comb
  begin
    unlock_cnt_next = unlock_cnt_reg;
    if (reinit)
      unlock_cnt_next = 3'h0;
    else if (ctrl_we && wbyte[wdc_pkg::UNLOCK_BIT] && wbyte[wdc_pkg::WDE_BIT])
      unlock_cnt_next = wdc_pkg::UNLOCK_LOAD;
    else if (unlock_active)
      unlock_cnt_next = unlock_cnt_reg - 3'h1;
  end

  // control fields; the timeout flag's set wins over the write-one and vector clears, not over a system reset
  always_comb
  begin
    ctrl_next = ctrl_reg;
    // flag: write one clears, zero ignored, vector clears
    if (ctrl_we && wbyte[wdc_pkg::FLAG_BIT])
      ctrl_next.flag = 1'b0;
    if (irq_vector_taken)
      ctrl_next.flag = 1'b0;
    if (set_flag)
      ctrl_next.flag = 1'b1;
    // interrupt enable; locked at zero under the fuse
    if (ctrl_we)
      ctrl_next.ie = wbyte[wdc_pkg::IE_BIT] & ~fuse_prog;
    else if (irq_vector_taken && wde_eff)
      ctrl_next.ie = 1'b0;
    // reset enable: setting is free, clearing needs unlock and no cause flag
    if (ctrl_we)
    begin
      if (wbyte[wdc_pkg::WDE_BIT])
        ctrl_next.reset_enable_bit = 1'b1;
      else if (unlock_active && !cause_reg)
        ctrl_next.reset_enable_bit = 1'b0;
    end
    // select change only inside the unlock window
    if (ctrl_we && unlock_active)
      ctrl_next.tsel = {wbyte[wdc_pkg::TSEL3_BIT], wbyte[wdc_pkg::TSEL_LO_MSB:0]};
    // any system reset returns to defaults, shortest period
    if (reinit)
    begin
      ctrl_next.flag = wdc_pkg::FLAG_RESET;
      ctrl_next.ie = wdc_pkg::IE_RESET;
      ctrl_next.reset_enable_bit = wdc_pkg::WDE_RESET;
      ctrl_next.tsel = wdc_pkg::TSEL_RESET;
    end
  end

  // cause flag: set by our own reset, cleared by writing zero; set wins
  always_comb
  begin
    cause_next = cause_reg;
    if (cause_we && !wbyte[wdc_pkg::CAUSE_BIT])
      cause_next = 1'b0;
    if (fire)
      cause_next = 1'b1;
  end

  // reset pulse stands for exactly one core cycle per timeout
  always_comb
  begin
    pulse_next = fire;
  end

  // bus registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus_state_reg <= wdc_pkg::BUS_IDLE;
      aphase_reg <= '0;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      bus_state_reg <= bus_state_next;
      aphase_reg <= aphase_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // watchdog registers; power-on reset also clears the cause flag
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg.flag <= wdc_pkg::FLAG_RESET;
      ctrl_reg.ie <= wdc_pkg::IE_RESET;
      ctrl_reg.reset_enable_bit <= wdc_pkg::WDE_RESET;
      ctrl_reg.tsel <= wdc_pkg::TSEL_RESET;
      unlock_cnt_reg <= 3'h0;
      cause_reg <= wdc_pkg::CAUSE_RESET;
      pulse_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      unlock_cnt_reg <= unlock_cnt_next;
      cause_reg <= cause_next;
      pulse_reg <= pulse_next;
    end
  end

  // outputs; the request gates the flag with both enables
  assign irq_req = ctrl_reg.flag & ie_eff & global_irq_enable;
  assign wdt_reset_pulse = pulse_reg;
  assign hreadyout = (bus_state_reg != wdc_pkg::BUS_RD_WAIT);
  assign hresp = wdc_pkg::HRESP_OKAY;
  assign hrdata = hrdata_reg;

endmodule : wdc_watchdog

// >>> rtl/wdc_pkg.sv
// shared constants and types of the watchdog timer control block
package wdc_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h00;
  localparam logic [7:0] RESET_CAUSE_ADDR = 8'h04;
  localparam int ADDR_W = 8;

  // field positions in watchdog_ctrl_status
  localparam int FLAG_BIT = 7;
  localparam int IE_BIT = 6;
  localparam int TSEL3_BIT = 5;
  localparam int UNLOCK_BIT = 4;
  localparam int WDE_BIT = 3;
  localparam int TSEL_LO_MSB = 2;

  // field position in the reset cause register
  localparam int CAUSE_BIT = 3;

  // reset values
  localparam logic [3:0] TSEL_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic IE_RESET = 1'b0;
  localparam logic WDE_RESET = 1'b0;
  localparam logic CAUSE_RESET = 1'b0;

  // fuse encoding: zero means programmed
  localparam logic FUSE_PROGRAMMED = 1'b0;

  // timing: unlock window in core cycles, one-cycle reset pulse
  localparam int UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES);
  localparam int RESET_PULSE_CYCLES = 1;

  // timeout: base oscillator cycles shifted left by the select code
  localparam int OSC_FREQ_HZ = 128000;
  localparam int BASE_OSC_CYCLES = 2048;
  localparam logic [3:0] TSEL_MAX_CODE = 4'h9;
  localparam int COUNT_W = 21;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // software-visible control fields
  typedef struct packed {
    logic flag;
    logic ie;
    logic reset_enable_bit;
    logic [3:0] tsel;
  } wdc_ctrl_t;

  // captured address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } wdc_aphase_t;

  // bus data-phase states
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_RD_WAIT = 4'b0100,
    BUS_RD_DONE = 4'b1000
  } wdc_bus_state_t;

endpackage : wdc_pkg

// >>> rtl/wdc_counter.sv
`timescale 1ns/100ps
// oscillator cycle counter with selectable timeout limit
module wdc_counter #(
  parameter int BASE_CYCLES = wdc_pkg::BASE_OSC_CYCLES,
  parameter int CNT_W = wdc_pkg::COUNT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic run,
  input wire logic osc_tick,
  input wire logic [3:0] tsel,
  output logic timeout,
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] limit;
  logic [3:0] code;

  // reserved codes fall back to the longest period, never to a short one
  always_comb
  begin
    code = (tsel > wdc_pkg::TSEL_MAX_CODE) ? wdc_pkg::TSEL_MAX_CODE : tsel;
    limit = CNT_W'(BASE_CYCLES) << code;
  end

  // count oscillator ticks; restart and stopped mode hold it at zero
  always_comb
  begin
    timeout = 1'b0;
    count_next = count_reg;
    if (restart || !run)
    begin
      count_next = '0;
    end
    else if (osc_tick)
    begin
      if (count_reg >= limit - CNT_W'(1))
      begin
        timeout = 1'b1;
        count_next = '0;
      end
      else
      begin
        count_next = count_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;

endmodule : wdc_counter

// >>> tb/wdc_watchdog_assertions.sv
`timescale 1ns/100ps
// port-level checks of the watchdog top, bound from the bench
module wdc_chk #(
  parameter int BASE_CYCLES = wdc_pkg::BASE_OSC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic osc_tick,
  input wire logic restart_instr,
  input wire logic global_irq_enable,
  input wire logic always_on_fuse,
  input wire logic irq_req,
  input wire logic wdt_reset_pulse,
  input wire logic [wdc_pkg::COUNT_W-1:0] watchdog_count
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  logic take;
  // an address phase the slave accepts
  assign take = hsel && hready && htrans == wdc_pkg::HTRANS_NONSEQ;
  // reads carry exactly one wait state, writes none
  bus_okay_a: assert property (hresp == wdc_pkg::HRESP_OKAY) else $error("bus error response");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  // an interrupt request needs the global enable and an unprogrammed fuse
  irq_gate_a: assert property (irq_req |-> global_irq_enable && always_on_fuse)
    else $error("irq without enables");
  pulse_width_a: assert property ($rose(wdt_reset_pulse) |=> !wdt_reset_pulse)
    else $error("reset pulse too long");
  pulse_cause_a: assert property ($rose(wdt_reset_pulse) |-> $past(osc_tick))
    else $error("reset pulse without tick");
  pulse_clear_a: assert property (wdt_reset_pulse |-> watchdog_count == '0)
    else $error("count not cleared by timeout reset");
  restart_zero_a: assert property (restart_instr |=> watchdog_count == '0)
    else $error("restart did not clear count");
  // the count moves only on oscillator ticks or back to zero
  count_hold_a: assert property (!osc_tick |=> $stable(watchdog_count) || watchdog_count == '0)
    else $error("count moved without tick");
  count_limit_a: assert property (int'(watchdog_count) < BASE_CYCLES * 512)
    else $error("count beyond longest period");
endmodule : wdc_chk

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int BASE = 4;
  localparam logic [7:0] CS = wdc_pkg::CTRL_STATUS_ADDR;
  localparam logic [7:0] RC = wdc_pkg::RESET_CAUSE_ADDR;
  localparam int STB_RESTART = 0;
  localparam int STB_VECTOR = 1;
  localparam int STB_OTHER = 2;
  logic sys_clk, reset, hsel, hwrite, hready, hreadyout, hresp, osc_tick, restart_instr;
  logic global_irq_enable, irq_vector_taken, other_reset_req, always_on_fuse, irq_req, wdt_reset_pulse;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [wdc_pkg::COUNT_W-1:0] watchdog_count;
  int num_errors = 0;
  int n_tests = 0;
  int n_pulse = 0;
  assign hready = hreadyout;
  wdc_watchdog #(.BASE_CYCLES(BASE)) DUT (.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .osc_tick(osc_tick), .restart_instr(restart_instr),
    .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken), .other_reset_req(other_reset_req),
    .always_on_fuse(always_on_fuse), .irq_req(irq_req), .wdt_reset_pulse(wdt_reset_pulse),
    .watchdog_count(watchdog_count));
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // pulses counted on the falling edge to stay clear of the sampling edge
  always @(negedge sys_clk)
  begin
    if (wdt_reset_pulse === 1'b1)
      n_pulse++;
  end
  task automatic complete_run;
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait for hready high at a rising edge; looked at half a cycle before that edge,
  // where hreadyout and hrdata have settled, so there is no race with the slave's flip-flops
  task automatic wait_rdy;
    int k;
    logic seen;
    k = 0;
    seen = 1'b0;
    while (seen !== 1'b1 && k < 20)
    begin
      @(negedge sys_clk);
      seen = hreadyout;
      rdv = hrdata;
      @(posedge sys_clk);
      k++;
    end
    if (seen !== 1'b1)
    begin
      num_errors++;
      complete_run();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= wdc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rdv, {24'h000000, e});
  endtask : rd
  // oscillator ticks, one idle cycle between them
  task automatic tk(input int n);
    repeat (n)
    begin
      osc_tick <= 1'b1;
      @(posedge sys_clk);
      osc_tick <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : tk
  // one-cycle strobe on a core-side input, chosen by number
  task automatic pulse(input int which);
    case (which)
      STB_RESTART: restart_instr <= 1'b1;
      STB_VECTOR: irq_vector_taken <= 1'b1;
      default: other_reset_req <= 1'b1;
    endcase
    @(posedge sys_clk);
    {restart_instr, irq_vector_taken, other_reset_req} <= 3'h0;
    @(posedge sys_clk);
  endtask : pulse
  // hang guard
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    {hsel, hwrite, osc_tick, restart_instr, global_irq_enable, irq_vector_taken, other_reset_req} = 7'h00;
    always_on_fuse = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(CS, 8'h00);
    rd(RC, 8'h00);
    rd(8'h08, 8'h00);
    global_irq_enable <= 1'b1;
    wr(CS, 8'h40);
    tk(3);
    chk(32'(watchdog_count), 32'h3);
    chk(32'(irq_req), 32'h0);
    tk(1);
    rd(CS, 8'hC0);
    chk(32'(irq_req), 32'h1);
    global_irq_enable <= 1'b0;
    @(posedge sys_clk);
    chk(32'(irq_req), 32'h0);
    global_irq_enable <= 1'b1;
    wr(CS, 8'h40);
    rd(CS, 8'hC0);
    wr(CS, 8'hC0);
    rd(CS, 8'h40);
    tk(4);
    pulse(STB_VECTOR);
    rd(CS, 8'h40);
    tk(2);
    pulse(STB_RESTART);
    chk(32'(watchdog_count), 32'h0);
    pulse(STB_OTHER);
    rd(CS, 8'h00);
    wr(CS, 8'h48);
    tk(4);
    rd(CS, 8'hC8);
    pulse(STB_VECTOR);
    rd(CS, 8'h08);
    wr(CS, 8'h48);
    tk(4);
    chk(32'(n_pulse), 32'h0);
    tk(4);
    chk(32'(n_pulse), 32'h1);
    rd(RC, 8'h08);
    rd(CS, 8'h08);
    wr(CS, 8'h18);
    wr(CS, 8'h00);
    repeat (6) @(posedge sys_clk);
    rd(CS, 8'h08);
    wr(RC, 8'h00);
    rd(RC, 8'h00);
    wr(CS, 8'h01);
    rd(CS, 8'h08);
    wr(CS, 8'h18);
    repeat (6) @(posedge sys_clk);
    wr(CS, 8'h01);
    rd(CS, 8'h08);
    wr(CS, 8'h18);
    wr(CS, 8'h0D);
    repeat (6) @(posedge sys_clk);
    rd(CS, 8'h0D);
    pulse(STB_RESTART);
    tk(127);
    chk(32'(n_pulse), 32'h1);
    tk(1);
    chk(32'(n_pulse), 32'h2);
    wr(RC, 8'h00);
    tk(5);
    chk(32'(watchdog_count), 32'h0);
    always_on_fuse <= 1'b0;
    wr(CS, 8'h40);
    rd(CS, 8'h08);
    tk(4);
    chk(32'(n_pulse), 32'h3);
    // a reserved select code under the fuse runs the longest period
    wr(CS, 8'h18);
    wr(CS, 8'h2F);
    repeat (6) @(posedge sys_clk);
    rd(CS, 8'h2F);
    pulse(STB_RESTART);
    tk(2047);
    chk(32'(watchdog_count), 32'h000007FF);
    chk(32'(n_pulse), 32'h3);
    tk(1);
    chk(32'(n_pulse), 32'h4);
    // power-on reset in mid-run clears the cause flag; the fuse still forces reset mode
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(RC, 8'h00);
    rd(CS, 8'h08);
    chk(32'(watchdog_count), 32'h0);
    complete_run();
  end
endmodule : tb
bind wdc_watchdog wdc_chk #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .osc_tick(osc_tick),
  .restart_instr(restart_instr), .global_irq_enable(global_irq_enable), .always_on_fuse(always_on_fuse),
  .irq_req(irq_req), .wdt_reset_pulse(wdt_reset_pulse), .watchdog_count(watchdog_count));
